// ==== design/alm_map.vh ====
// Register offsets, field positions, reset values and timing counts of the alarm block.
// What this block does
// [R1] Alarm pin is also read as an input for external system errors.
// [R2] Polarity 0: drive low on error, float otherwise; polarity 1: reversed.
// [R3] During line driver shutdown the alarm pin floats and shows no error.
// [R4] Three-bit hold time code selects 0 to 87.5 ms in 12.5 ms steps.
// [R5] Pull-up enable bit switches the internal pull-up source on the pin.
// [R6] Ten-bit alarm mask lets each event change the pin; cleared bit ignores it.
// [R7] Mask bits 9..6: line count, tracking, lost tracking, configuration error.
// [R8] Mask bits 5..0: overtemp, index enable, max, min, clipping, signal loss.
// [R9] With mask bit 4 and hold code 0 the raw index enable drives the pin.
// [R10] Integrators use low-active polarity when external system errors must be seen.
// [R11] Count sine cycles between zero pulses; mismatch with reference sets error.
// [R12] Direction change pauses the check until the next zero pulse.
// [R13] Test output shows that the first line count check has finished.
// [R14] Line count reference is 14 bits; expected cycles equal code plus one.
// [R15] Enabled events are ORed; alarm holds at least the selected time.
// [R16] A separate shutdown mask selects events that turn off the drivers.
`ifndef ALM_MAP_VH
`define ALM_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ALM_ADDR_MASK_LO   8'h14
`define ALM_ADDR_CFG       8'h15
`define ALM_ADDR_SHUT_LO   8'h16
`define ALM_ADDR_PULLUP    8'h17
`define ALM_ADDR_LCNT_LO   8'h1F
`define ALM_ADDR_LCNT_HI   8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ALM_POL_BIT        2
`define ALM_HOLD_MSB       5
`define ALM_HOLD_LSB       3
`define ALM_PU_BIT         2
`define ALM_EV_INDEX       4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ALM_MASK_RST       10'h000
`define ALM_SHUT_RST       10'h000
`define ALM_HOLD_RST       3'h0
`define ALM_LCNT_RST       14'h0000

// ----------------------------------------------------------------
// Timing: hold step 12.5 ms in ns at 25 ns clock period
// ----------------------------------------------------------------
`define ALM_HOLD_STEP_NS   12500000
`define ALM_CLK_NS         25
`define ALM_HOLD_STEP_CYC  (`ALM_HOLD_STEP_NS / `ALM_CLK_NS)
// Cycles after release before a low pin may count as an external error.
`define ALM_SETTLE_CYC     3'h4

`endif

// ==== design/alm_sync.v ====
// Three-stage synchroniser with agreement filter for a pin input.
`timescale 1ns/1ps
module alm_sync
(
	input  wire clock_in,
	input  wire sys_rst_in,
	input  wire async_in,
	output reg  level_out
);
	reg s1;
	reg s2;
	reg s3;

	// Stage chain; the level changes once stages two and three agree.
	always @(posedge clock_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			// The pin idles high, so a low start would fake an external error.
			s1        <= 1'b1;
			s2        <= 1'b1;
			s3        <= 1'b1;
			level_out <= 1'b1;
		end
		else
		begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level_out <= s3;
		end
	end
endmodule // alm_sync

// ==== design/alm_line_count.v ====
// Line count monitor: sine cycles between zero pulses against the reference.
`timescale 1ns/1ps
`include "alm_map.vh"
module alm_line_count
(
	input  wire        clock_in,
	input  wire        sys_rst_in,
	input  wire        cycle_in,
	input  wire        dir_in,
	input  wire        zero_in,
	input  wire [13:0] expected_cycle_count_in,
	output reg         line_count_error_out,
	output reg         first_check_done_out
);
	reg [14:0] count;
	reg        armed;
	reg        last_dir;

	// Cycle counting, comparison at each zero pulse except the first after reset or reversal, pause on reversal.
	always @(posedge clock_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			count                <= 15'h0000;
			armed                <= 1'b0;
			last_dir             <= 1'b0;
			line_count_error_out <= 1'b0;
			first_check_done_out <= 1'b0;
		end
		else
		begin
			last_dir <= dir_in;
			if (dir_in != last_dir)
			begin
				armed <= 1'b0; // R12
				count <= 15'h0000;
			end
			else if (zero_in)
			begin
				if (armed)
				begin
					line_count_error_out <= (count != ({1'b0, expected_cycle_count_in} + 15'h0001)); // R11 R14
					first_check_done_out <= 1'b1; // R13
				end
				armed <= 1'b1; // R12
				count <= 15'h0000;
			end
			else if (cycle_in && armed && count != 15'h7FFF)
				count <= count + 15'h0001; // R11
		end
	end
endmodule // alm_line_count

// ==== design/alm_top.v ====
// Alarm output logic with register port, polarity, hold time and line count check.
`timescale 1ns/1ps
`include "alm_map.vh"
module alm_top
(
	input  wire        clock_in,
	input  wire        sys_rst_in,
	input  wire        reg_wr_in,
	input  wire [7:0]  reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	output reg  [7:0]  reg_rdata_out,
	input  wire [9:0]  event_in,
	input  wire        index_enable_in,
	input  wire        cycle_in,
	input  wire        dir_in,
	input  wire        zero_in,
	input  wire        alarm_pin_in,
	output reg         alarm_pin_out,
	output reg         alarm_pin_oe_out,
	output reg         alarm_pullup_enable_out,
	output reg         driver_shutdown_out,
	output reg         system_error_out,
	output reg         test_probe_one_out
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg  [9:0]  alarm_event_mask;
	reg  [9:0]  shutdown_event_mask;
	reg         alarm_polarity;
	reg  [2:0]  alarm_hold_time;
	reg         alarm_pullup_enable;
	reg  [13:0] expected_cycle_count;
	reg  [21:0] hold_cnt;
	reg         alarm_active;
	wire        pin_level;
	wire        lc_error;
	wire        lc_done;
	wire [9:0]  events;
	wire        alarm_raw;
	wire [21:0] hold_load;
	wire        next_shutdown;
	reg  [2:0]  release_cnt;

	// Hold time in cycles for a given code.
	// The product fits in 22 bits for every code; the cut is on purpose.
	function [21:0] alm_hold_cycles;
		input [2:0]  code;
		reg   [31:0] product;
		begin
			product         = code * `ALM_HOLD_STEP_CYC;
			alm_hold_cycles = product[21:0];
		end
	endfunction

	// External error from the pin, seen only when pin is not driven by us.
	alm_sync u_sync
	(
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.async_in   (alarm_pin_in),
		.level_out  (pin_level)
	);

	alm_line_count u_lc
	(
		.clock_in                (clock_in),
		.sys_rst_in              (sys_rst_in),
		.cycle_in                (cycle_in),
		.dir_in                  (dir_in),
		.zero_in                 (zero_in),
		.expected_cycle_count_in (expected_cycle_count),
		.line_count_error_out    (lc_error),
		.first_check_done_out    (lc_done)
	);

	// Event vector; bit 9 is the internal line count error ORed with event_in[9].
	assign events    = {lc_error | event_in[9], event_in[8:0]}; // R7 R8
	assign alarm_raw = |(events & alarm_event_mask); // R6 R15
	assign hold_load = alm_hold_cycles(alarm_hold_time); // R4
	// Shutdown decision, shared by the output and the pin release.
	assign next_shutdown = |(events & shutdown_event_mask); // R16

	// ----------------------------------------------------------------
	// Register writes and reads
	// ----------------------------------------------------------------
	always @(posedge clock_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			alarm_event_mask     <= `ALM_MASK_RST;
			shutdown_event_mask  <= `ALM_SHUT_RST;
			alarm_polarity       <= 1'b0;
			alarm_hold_time      <= `ALM_HOLD_RST;
			alarm_pullup_enable  <= 1'b0;
			expected_cycle_count <= `ALM_LCNT_RST;
			reg_rdata_out        <= 8'h00;
		end
		else
		begin
			if (reg_wr_in)
			begin
				case (reg_addr_in)
					`ALM_ADDR_MASK_LO: alarm_event_mask[7:0] <= reg_wdata_in;
					`ALM_ADDR_CFG:
					begin
						alarm_event_mask[9:8] <= reg_wdata_in[1:0];
						alarm_polarity        <= reg_wdata_in[`ALM_POL_BIT]; // R2
						alarm_hold_time       <= reg_wdata_in[`ALM_HOLD_MSB:`ALM_HOLD_LSB]; // R4
					end
					`ALM_ADDR_SHUT_LO: shutdown_event_mask[7:0] <= reg_wdata_in; // R16
					`ALM_ADDR_PULLUP:
					begin
						shutdown_event_mask[9:8] <= reg_wdata_in[1:0];
						alarm_pullup_enable      <= reg_wdata_in[`ALM_PU_BIT]; // R5
					end
					`ALM_ADDR_LCNT_LO: expected_cycle_count[7:0] <= reg_wdata_in; // R14
					`ALM_ADDR_LCNT_HI: expected_cycle_count[13:8] <= reg_wdata_in[5:0];
					default: ;
				endcase
			end
			case (reg_addr_in)
				`ALM_ADDR_MASK_LO: reg_rdata_out <= alarm_event_mask[7:0];
				`ALM_ADDR_CFG:     reg_rdata_out <= {2'h0, alarm_hold_time, alarm_polarity,
					alarm_event_mask[9:8]};
				`ALM_ADDR_SHUT_LO: reg_rdata_out <= shutdown_event_mask[7:0];
				`ALM_ADDR_PULLUP:  reg_rdata_out <= {5'h00, alarm_pullup_enable,
					shutdown_event_mask[9:8]};
				`ALM_ADDR_LCNT_LO: reg_rdata_out <= expected_cycle_count[7:0];
				`ALM_ADDR_LCNT_HI: reg_rdata_out <= {2'h0, expected_cycle_count[13:8]};
				default:           reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Alarm hold timer and pin drive
	// ----------------------------------------------------------------
	always @(posedge clock_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			hold_cnt                <= 22'h000000;
			alarm_active            <= 1'b0;
			alarm_pin_out           <= 1'b0;
			alarm_pin_oe_out        <= 1'b0;
			alarm_pullup_enable_out <= 1'b0;
			driver_shutdown_out     <= 1'b0;
			system_error_out        <= 1'b0;
			test_probe_one_out      <= 1'b0;
			release_cnt             <= 3'h0;
		end
		else
		begin
			// Hold the alarm for at least the selected time after the cause clears.
			if (alarm_raw)
			begin
				alarm_active <= 1'b1;
				hold_cnt     <= hold_load; // R15
			end
			else if (hold_cnt != 22'h000000)
				hold_cnt <= hold_cnt - 22'h000001; // R4 R15
			else
				alarm_active <= 1'b0;
			driver_shutdown_out <= next_shutdown; // R16
			alarm_pin_out       <= 1'b0;
			// The pin is released in the same cycle as the shutdown output rises.
			if (next_shutdown)
				alarm_pin_oe_out <= 1'b0; // R3
			else if (alarm_hold_time == 3'h0 && alarm_event_mask[`ALM_EV_INDEX])
				alarm_pin_oe_out <= alarm_polarity ^ index_enable_in; // R9
			else
				alarm_pin_oe_out <= alarm_polarity ^ (alarm_raw | alarm_active); // R2
			// Cycles since release; our own low must clear the synchroniser first.
			if (alarm_pin_oe_out)
				release_cnt <= 3'h0;
			else if (release_cnt != 3'h7)
				release_cnt <= release_cnt + 3'h1;
			// External low level seen while floating in low-active polarity.
			system_error_out <= !alarm_polarity && !alarm_pin_oe_out && !pin_level
				&& release_cnt >= `ALM_SETTLE_CYC && !next_shutdown; // R1 R10
			alarm_pullup_enable_out <= alarm_pullup_enable; // R5
			test_probe_one_out      <= lc_done; // R13
		end
	end
endmodule // alm_top

// ==== verif/alm_properties.sv ====
// Port checker of the alarm output block.
`timescale 1ns/1ps
module alm_properties
(
	input wire       clock_in, sys_rst_in, reg_wr_in, index_enable_in, zero_in,
	input wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
	input wire [9:0] event_in,
	input wire       alarm_pin_out, alarm_pin_oe_out, alarm_pullup_enable_out,
	input wire       driver_shutdown_out, system_error_out, test_probe_one_out
);
	reg [9:0]  mask;
	reg [9:0]  smask;
	reg [2:0]  hold;
	reg        pol, pu;
	reg [23:0] run;
	wire       idx = mask[4] && hold == 3'h0;
	// Shadow of the written setup and the length of the running alarm.
	always @(posedge clock_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			{mask, hold, pol, pu, run} <= 39'h0;
			smask <= 10'h000;
		end
		else
		begin
			run <= alarm_pin_oe_out ? run + 24'h1 : 24'h0;
			if (reg_wr_in && reg_addr_in == 8'h14)
				mask[7:0] <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == 8'h15)
				{hold, pol, mask[9:8]} <= reg_wdata_in[5:0];
			if (reg_wr_in && reg_addr_in == 8'h16)
				smask[7:0] <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == 8'h17)
			begin
				pu         <= reg_wdata_in[2];
				smask[9:8] <= reg_wdata_in[1:0];
			end
		end
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	a_pin_never_high: assert property (!alarm_pin_out) else $error("pin high");
	a_mask_event: assert property (|(event_in & mask) && !pol && !idx
		|=> alarm_pin_oe_out || driver_shutdown_out) else $error("event lost");
	a_shutdown_float: assert property (driver_shutdown_out |-> !alarm_pin_oe_out)
		else $error("pin driven in shutdown");
	a_shutdown_mask: assert property (|(event_in & smask) |=> driver_shutdown_out)
		else $error("shutdown event lost");
	a_sys_error_pol: assert property (system_error_out |-> !$past(pol))
		else $error("system error at high polarity");
	a_index_mode: assert property (idx && !pol && index_enable_in
		|-> ##[1:2] alarm_pin_oe_out || driver_shutdown_out) else $error("index lost");
	a_hold_min: assert property ($fell(alarm_pin_oe_out) && !pol && !driver_shutdown_out
		|-> run >= hold * 500000) else $error("alarm too short");
	a_count_readback: assert property (reg_wr_in && reg_addr_in == 8'h20 ##1
		(reg_addr_in == 8'h20 && !reg_wr_in)
		|=> reg_rdata_out == {2'h0, $past(reg_wdata_in[5:0], 2)}) else $error("count read");
	a_pullup_follow: assert property ($past(pu) == pu && $past(pu, 2) == pu
		|-> alarm_pullup_enable_out == pu) else $error("pull-up wrong");
	a_probe_zero: assert property ($rose(test_probe_one_out)
		|-> $past(zero_in) || $past(zero_in, 2) || $past(zero_in, 3)) else $error("probe");
endmodule // alm_properties

// ==== verif/alm_ctrl_model.sv ====
// System controller on the shared open-drain alarm line.
`timescale 1ns/1ps
module alm_ctrl_model
(
	input  wire clock_in,
	input  wire oe_in,
	input  wire pullup_in,
	input  wire pull_low_in,
	output wire line_out
);
	reg last = 1'b0;
	// Any low driver wins; a floating wire without pull-up never holds a value.
	assign line_out = (oe_in || pull_low_in) ? 1'b0 : (pullup_in ? 1'b1 : ~last);
	// Remember the line so that a floating wire changes every cycle.
	always @(posedge clock_in)
		last <= line_out;
endmodule // alm_ctrl_model

// ==== verif/alm_top_test.sv ====
// Self-checking bench of the alarm block against a reference model.
`timescale 1ns/1ps
module alm_top_test;
	reg        clock_in = 1'b0, sys_rst_in = 1'b1, wr_en = 1'b0, idx = 1'b0, m_pol = 1'b0;
	reg        cyc = 1'b0, dir = 1'b0, zero = 1'b0, pull_low = 1'b0, m_pu = 1'b0;
	reg  [7:0] addr = 8'h00, wdata = 8'h00;
	reg  [9:0] ev = 10'h000, m_mask = 10'h000, m_shut = 10'h000, m;
	reg  [2:0] m_hold = 3'h0;
	reg [13:0] m_cnt = 14'h0000;
	reg [31:0] rng = 32'hA99CD0E2;
	wire [7:0] rdata;
	wire       line, oe, pu, shut, sys_err, probe;
	integer    n_mismatch = 0, n_compared = 0, i;
	alm_top uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_wr_in(wr_en),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .event_in(ev),
		.index_enable_in(idx), .cycle_in(cyc), .dir_in(dir), .zero_in(zero),
		.alarm_pin_in(line), .alarm_pin_out(), .alarm_pin_oe_out(oe),
		.alarm_pullup_enable_out(pu), .driver_shutdown_out(shut),
		.system_error_out(sys_err), .test_probe_one_out(probe));
	alm_ctrl_model ctrl (.clock_in(clock_in), .oe_in(oe), .pullup_in(pu),
		.pull_low_in(pull_low), .line_out(line));
	// Free-running bench clock.
	initial
		forever #12.5 clock_in = ~clock_in;
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	function exp_oe(input [9:0] e);
		exp_oe = ~|(e & m_shut) & (m_pol ^ |(e & m_mask));
	endfunction
	task step(input integer n);
		repeat (n) @(negedge clock_in);
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	// Register write that also updates the model.
	task wr(input [7:0] a, input [7:0] d);
	begin
		case (a)
			8'h14: m_mask[7:0] = d;
			8'h15: {m_hold, m_pol, m_mask[9:8]} = d[5:0];
			8'h16: m_shut[7:0] = d;
			8'h17: {m_pu, m_shut[9:8]} = d[2:0];
			8'h1F: m_cnt[7:0] = d;
			8'h20: m_cnt[13:8] = d[5:0];
		endcase
		wr_en = 1'b1; addr = a; wdata = d; step(1);
		wr_en = 1'b0; step(1);
	end
	endtask
	task rd(input [7:0] a);
		reg [7:0] e;
	begin
		addr = a; step(2);
		case (a)
			8'h14: e = m_mask[7:0];
			8'h15: e = {2'h0, m_hold, m_pol, m_mask[9:8]};
			8'h16: e = m_shut[7:0];
			8'h17: e = {5'h00, m_pu, m_shut[9:8]};
			8'h1F: e = m_cnt[7:0];
			8'h20: e = {2'h0, m_cnt[13:8]};
			default: e = 8'h00;
		endcase
		chk(rdata, e);
	end
	endtask
	// Sine cycles, then the zero pulse that closes the interval.
	task frame(input integer n);
	begin
		repeat (n) begin cyc = 1'b1; step(1); cyc = 1'b0; step(1); end
		zero = 1'b1; step(1); zero = 1'b0; step(4);
	end
	endtask
	task final_report;
	begin
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	// Main sequence of scenarios.
	initial
	begin
		step(12); sys_rst_in = 1'b0;
		for (i = 0; i < 7; i = i + 1)
		begin
			rng = xs(rng);
			wr(i == 6 ? 8'h21 : (i < 4 ? 8'h14 + i : 8'h1B + i), rng[7:0]);
			rd(i == 6 ? 8'h21 : (i < 4 ? 8'h14 + i : 8'h1B + i));
		end
		chk(pu, m_pu);
		wr(8'h16, 8'h00); wr(8'h17, 8'h04);
		for (i = 0; i < 10; i = i + 1)
			if (i != 4)
			begin
				m = 10'h001 << i; rng = xs(rng);
				wr(8'h14, m[7:0]); wr(8'h15, {6'h00, m[9:8]});
				ev = rng[9:0] | m; step(2); chk(oe, exp_oe(ev));
				ev = rng[9:0] & ~m; step(2); chk(oe, exp_oe(ev));
			end
		wr(8'h14, 8'h01); wr(8'h15, 8'h04);
		for (i = 0; i < 2; i = i + 1) begin ev = i; step(2); chk(oe, exp_oe(ev)); end
		ev = 10'h000; wr(8'h15, 8'h00); pull_low = 1'b1;
		for (i = 0; i < 8 && sys_err !== 1'b1; i = i + 1) step(1);
		chk(sys_err, 1'b1);
		wr(8'h15, 8'h04); step(8); chk(sys_err, 1'b0);
		pull_low = 1'b0; ev = 10'h002; wr(8'h15, 8'h00); wr(8'h14, 8'h02);
		for (i = 0; i < 2; i = i + 1)
		begin
			wr(8'h16, i ? 8'h00 : 8'h02); step(1);
			chk(shut, |(ev & m_shut));
			chk(oe, exp_oe(ev));
		end
		ev = 10'h000; wr(8'h14, 8'h10);
		for (i = 0; i < 4; i = i + 1) begin idx = i; step(2); chk(oe, idx); end
		wr(8'h14, 8'h01); wr(8'h15, 8'h08); ev = 10'h001; step(1); ev = 10'h000;
		step(1000); chk(oe, 1'b1);
		sys_rst_in = 1'b1; step(2); chk(oe, 1'b0);
		{m_mask, m_shut, m_hold, m_pol, m_pu, m_cnt} = 40'h0; sys_rst_in = 1'b0;
		rd(8'h15);
		wr(8'h1F, 8'h09); wr(8'h20, 8'h00); wr(8'h15, 8'h02); wr(8'h17, 8'h04);
		frame(0); chk(probe, 1'b0);
		frame(m_cnt + 1); chk(oe, 1'b0); chk(probe, 1'b1);
		frame(m_cnt); chk(oe, 1'b1);
		frame(m_cnt + 1); chk(oe, 1'b0);
		dir = 1'b1; frame(3); chk(oe, 1'b0);
		frame(m_cnt); chk(oe, 1'b1);
		final_report;
	end
endmodule // alm_top_test

bind alm_top alm_properties chk_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
	.reg_wr_in(reg_wr_in), .index_enable_in(index_enable_in), .zero_in(zero_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.event_in(event_in), .alarm_pin_out(alarm_pin_out), .alarm_pin_oe_out(alarm_pin_oe_out),
	.alarm_pullup_enable_out(alarm_pullup_enable_out),
	.driver_shutdown_out(driver_shutdown_out), .system_error_out(system_error_out),
	.test_probe_one_out(test_probe_one_out));
